// ===== core/link_cfg_regs.sv
// Fail-safe mapping and serial-link configuration registers with the
// watchdog and output selection they steer.
// Assumes the frame decoder drives the register port on this clock and
// loads the nonvolatile image with one pulse after reset release.
`timescale 1ns/1ps
module link_cfg_regs
   import cfg_pkg::*;
#(
   parameter int unsigned US_CYCLES = CYC_PER_US
)
(
   // Clock and reset
   input  wire logic                I_SYS_CLK,
   input  wire logic                I_RST_B,
   // Register port from the frame decoder
   input  wire logic                i_reg_wr,
   input  wire logic                i_reg_rd,
   input  wire logic [7:0]          i_reg_addr,
   input  wire logic [7:0]          i_reg_wdata,
   output logic [7:0]               o_reg_rdata,
   output logic                     o_reg_rvalid,
   // Nonvolatile image load
   input  wire logic                i_nvm_load,
   input  wire cfg_image_s          i_nvm_image,
   output logic                     o_cfg_loaded,
   // Link events
   input  wire logic                i_frame_ok,
   input  wire logic                i_fs_exit,
   // Pins
   input  wire logic                i_failsafe_input_first,
   input  wire logic                i_failsafe_input_second,
   input  wire logic                i_address_strap_pin_two,
   input  wire logic                i_address_strap_pin_one,
   input  wire logic                i_address_strap_pin_zero,
   // Normal output drive
   input  wire out_grp_s            i_norm_drive,
   // Outputs
   output out_grp_s                 o_out_drive,
   output logic                     o_failsafe,
   output logic                     o_acknowledge_enable,
   output logic [BWT_W-1:0]         o_break_wait_time_us,
   output logic [3:0]               o_bus_address
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   // Three stages; a value is taken only once stages two and three
   // agree, which rejects a single-cycle glitch on the pins.
   logic [4:0] pin_raw;
   logic [4:0] sync1_reg, sync2_reg, sync3_reg;
   logic [4:0] pin_reg,   pin_next;

   assign pin_raw = {i_failsafe_input_second, i_failsafe_input_first,
                     i_address_strap_pin_two, i_address_strap_pin_one,
                     i_address_strap_pin_zero};

   always_comb
   begin
      pin_next = pin_reg;
      for (int i = 0; i < 5; i++)
         if (sync2_reg[i] == sync3_reg[i])
            pin_next[i] = sync3_reg[i];
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         sync3_reg <= '0;
         pin_reg   <= '0;
      end
      else
      begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         pin_reg   <= pin_next;
      end
   end

   logic       fs_in_first;
   logic       fs_in_second;
   logic [2:0] strap_addr;

   assign fs_in_second = pin_reg[4];
   assign fs_in_first  = pin_reg[3];
   assign strap_addr   = pin_reg[2:0];

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   logic [7:0] map_reg,    map_next;
   logic [7:0] link_reg,   link_next;
   logic [7:0] addr_reg,   addr_next;
   logic       loaded_reg, loaded_next;
   logic [7:0] rdata_reg,  rdata_next;
   logic       rvalid_reg, rvalid_next;

   always_comb
   begin
      map_next    = map_reg;
      link_next   = link_reg;
      addr_next   = addr_reg;
      loaded_next = loaded_reg;
      if (i_nvm_load)
      begin
         map_next    = i_nvm_image.map_gh   & MAP_GH_MASK;
         link_next   = i_nvm_image.link_cfg & LINK_CFG_MASK;
         addr_next   = i_nvm_image.addr_cfg & ADDR_CFG_MASK;
         loaded_next = 1'b1;
      end
      else if (i_reg_wr)
      begin
         unique case (i_reg_addr)
            MAP_GH_OFS:   map_next  = i_reg_wdata & MAP_GH_MASK;
            LINK_CFG_OFS: link_next = i_reg_wdata & LINK_CFG_MASK;
            ADDR_CFG_OFS: addr_next = i_reg_wdata & ADDR_CFG_MASK;
            default:      map_next  = map_reg;
         endcase
      end
   end

   // Unmapped reads return zero so the decoder can answer every address.
   always_comb
   begin
      rvalid_next = i_reg_rd;
      rdata_next  = 8'h00;
      if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            MAP_GH_OFS:   rdata_next = map_reg;
            LINK_CFG_OFS: rdata_next = link_reg;
            ADDR_CFG_OFS: rdata_next = addr_reg;
            default:      rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         map_reg    <= CFG_RST;
         link_reg   <= CFG_RST;
         addr_reg   <= CFG_RST;
         loaded_reg <= 1'b0;
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end
      else
      begin
         map_reg    <= map_next;
         link_reg   <= link_next;
         addr_reg   <= addr_next;
         loaded_reg <= loaded_next;
         rdata_reg  <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   logic [3:0] wdt_code;
   logic [2:0] bwt_code;
   logic [2:0] map_h;
   logic [2:0] map_g;

   assign wdt_code = link_reg[WDT_LSB +: 4];
   assign bwt_code = link_reg[BWT_LSB +: 3];
   assign map_h    = map_reg[MAP_H_LSB +: 3];
   assign map_g    = map_reg[MAP_G_LSB +: 3];

   // ------------------------------------------------------------
   // Microsecond divider and watchdog
   // ------------------------------------------------------------
   logic [15:0] div_reg,  div_next;
   logic        tick_reg, tick_next;
   logic        wd_trip;
   logic        wd_run;

   // Watchdog stays quiet until the image is in, so reset zeros in the
   // timing register cannot be mistaken for a real configuration.
   assign wd_run = loaded_reg;

   always_comb
   begin
      tick_next = 1'b0;
      div_next  = div_reg + 16'd1;
      if (div_reg >= 16'(US_CYCLES - 1))
      begin
         div_next  = '0;
         tick_next = 1'b1;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         div_reg  <= '0;
         tick_reg <= 1'b0;
      end
      else
      begin
         div_reg  <= div_next;
         tick_reg <= tick_next;
      end
   end

   link_watchdog u_watchdog (
      .i_sys_clk  (I_SYS_CLK),
      .i_rst_b    (I_RST_B),
      .i_us_tick  (tick_reg),
      .i_frame_ok (i_frame_ok),
      .i_code     (wd_run ? wdt_code : WDT_OFF),
      .o_trip     (wd_trip),
      .o_count    ()
   );

   // ------------------------------------------------------------
   // Fail-safe state and outputs
   // ------------------------------------------------------------
   logic             fs_reg,    fs_next;
   out_grp_s         drive_reg, drive_next;
   logic             ack_reg,   ack_next;
   logic [BWT_W-1:0] bwt_reg,   bwt_next;
   logic [3:0]       badr_reg,  badr_next;

   // A trip in the same cycle as an exit request keeps fail-safe set.
   assign fs_next = wd_trip | (fs_reg & ~i_fs_exit);

   always_comb
   begin
      drive_next = i_norm_drive;
      if (fs_reg)
         for (int i = 0; i < 3; i++)
         begin
            drive_next.h[i] = map_h[i] ? fs_in_second : fs_in_first;
            drive_next.g[i] = map_g[i] ? fs_in_second : fs_in_first;
         end
      ack_next  = link_reg[ACK_BIT];
      bwt_next  = bwt_us(bwt_code);
      badr_next = addr_reg[ASRC_BIT] ? addr_reg[DADDR_LSB +: 4]
                                     : {1'b0, strap_addr};
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_B)
   begin
      if (!I_RST_B)
      begin
         fs_reg    <= 1'b0;
         drive_reg <= '0;
         ack_reg   <= 1'b0;
         bwt_reg   <= '0;
         badr_reg  <= 4'h0;
      end
      else
      begin
         fs_reg    <= fs_next;
         drive_reg <= drive_next;
         ack_reg   <= ack_next;
         bwt_reg   <= bwt_next;
         badr_reg  <= badr_next;
      end
   end

   assign o_reg_rdata          = rdata_reg;
   assign o_reg_rvalid         = rvalid_reg;
   assign o_cfg_loaded         = loaded_reg;
   assign o_out_drive          = drive_reg;
   assign o_failsafe           = fs_reg;
   assign o_acknowledge_enable = ack_reg;
   assign o_break_wait_time_us = bwt_reg;
   assign o_bus_address        = badr_reg;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RST_B);

   sequence s_fs_held;
      fs_reg ##1 fs_reg;
   endsequence

   property p_map_select;
      s_fs_held |-> o_out_drive.h[0] ==
         ($past(map_h[0]) ? $past(fs_in_second) : $past(fs_in_first));
   endproperty
   a_map_select: assert property (p_map_select)
      else $error("fail-safe output does not follow mapped input");

   property p_map_reserved;
      (i_reg_rd && i_reg_addr == MAP_GH_OFS) |=>
         o_reg_rvalid && o_reg_rdata[7] == 1'b0 && o_reg_rdata[3] == 1'b0;
   endproperty
   a_map_reserved: assert property (p_map_reserved)
      else $error("map register reserved bit reads one");

   property p_nvm_load;
      i_nvm_load |=> o_cfg_loaded
         && map_reg == ($past(i_nvm_image.map_gh) & MAP_GH_MASK)
         && link_reg == $past(i_nvm_image.link_cfg);
   endproperty
   a_nvm_load: assert property (p_nvm_load)
      else $error("configuration not loaded from image");

   property p_wdt_disabled;
      (wdt_code == WDT_OFF && !fs_reg)[*3] |=> !fs_reg;
   endproperty
   a_wdt_disabled: assert property (p_wdt_disabled)
      else $error("fail-safe entered with watchdog disabled");

   property p_wdt_direct;
      (loaded_reg && wdt_code >= WDT_ZERO_MIN) ##1
      (wdt_code >= WDT_ZERO_MIN) |=> ##1 fs_reg;
   endproperty
   a_wdt_direct: assert property (p_wdt_direct)
      else $error("direct fail-safe code did not enter fail-safe");

   // The output register lags the field by one cycle, so compare it with
   // the code that was in place at the previous edge.
   property p_break_wait;
      $stable(bwt_code) |=>
         o_break_wait_time_us == bwt_us($past(bwt_code));
   endproperty
   a_break_wait: assert property (p_break_wait)
      else $error("break wait time wrong for code");

   property p_ack_enable;
      $stable(link_reg) |=>
         o_acknowledge_enable == $past(link_reg[ACK_BIT]);
   endproperty
   a_ack_enable: assert property (p_ack_enable)
      else $error("acknowledge enable does not follow bit zero");

   property p_addr_source;
      ($stable(addr_reg) && $stable(strap_addr)) |=> o_bus_address ==
         ($past(addr_reg[ASRC_BIT]) ? $past(addr_reg[3:0])
                                    : {1'b0, $past(strap_addr)});
   endproperty
   a_addr_source: assert property (p_addr_source)
      else $error("bus address from wrong source");

   property p_addr_reserved;
      (i_reg_rd && i_reg_addr == ADDR_CFG_OFS) |=>
         o_reg_rdata[7:5] == 3'b000;
   endproperty
   a_addr_reserved: assert property (p_addr_reserved)
      else $error("address register reserved bits read one");

   property p_fs_set_wins;
      (wd_trip && i_fs_exit) |=> fs_reg;
   endproperty
   a_fs_set_wins: assert property (p_fs_set_wins)
      else $error("watchdog trip lost to exit request");

endmodule : link_cfg_regs

// ===== inc/cfg_pkg.sv
// Constants, types and decode functions for the link configuration bank.
// Assumes one 25 MHz clock and a register port driven by the frame decoder.
package cfg_pkg;

   // ------------------------------------------------------------
   // Register offsets and writable masks
   // ------------------------------------------------------------
   localparam logic [7:0] MAP_GH_OFS    = 8'h83;
   localparam logic [7:0] LINK_CFG_OFS  = 8'h84;
   localparam logic [7:0] ADDR_CFG_OFS  = 8'h85;
   localparam logic [7:0] MAP_GH_MASK   = 8'h77;
   localparam logic [7:0] LINK_CFG_MASK = 8'hff;
   localparam logic [7:0] ADDR_CFG_MASK = 8'h1f;
   localparam logic [7:0] CFG_RST       = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int MAP_H_LSB = 4;
   localparam int MAP_G_LSB = 0;
   localparam int WDT_LSB   = 4;
   localparam int BWT_LSB   = 1;
   localparam int ACK_BIT   = 0;
   localparam int ASRC_BIT  = 4;
   localparam int DADDR_LSB = 0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned NS_PER_US     = 1000;
   localparam int unsigned CYC_PER_US    = NS_PER_US / CLK_PERIOD_NS;
   localparam int          WD_CNT_W      = 19;
   localparam int          BWT_W         = 13;
   localparam logic [3:0]  WDT_OFF       = 4'h0;
   localparam logic [3:0]  WDT_ZERO_MIN  = 4'hc;

   typedef enum logic [1:0] {
      WD_OFF  = 2'b00,
      WD_RUN  = 2'b01,
      WD_TRIP = 2'b11
   } wd_state_e;

   typedef struct packed {
      logic [7:0] addr_cfg;
      logic [7:0] link_cfg;
      logic [7:0] map_gh;
   } cfg_image_s;

   typedef struct packed {
      logic [2:0] h;
      logic [2:0] g;
   } out_grp_s;

   // ------------------------------------------------------------
   // Decode functions
   // ------------------------------------------------------------
   // Timeout in microseconds; zero for disabled and for direct codes.
   function automatic logic [WD_CNT_W-1:0] wdt_us(input logic [3:0] code);
      logic [WD_CNT_W-1:0] t;
      t = '0;
      unique case (code)
         4'h1: t = 19'd200;
         4'h2: t = 19'd500;
         4'h3: t = 19'd1000;
         4'h4: t = 19'd2000;
         4'h5: t = 19'd5000;
         4'h6: t = 19'd10000;
         4'h7: t = 19'd20000;
         4'h8: t = 19'd50000;
         4'h9: t = 19'd100000;
         4'ha: t = 19'd200000;
         4'hb: t = 19'd500000;
         default: t = '0;
      endcase
      return t;
   endfunction : wdt_us

   function automatic logic [BWT_W-1:0] bwt_us(input logic [2:0] code);
      logic [BWT_W-1:0] t;
      t = '0;
      unique case (code)
         3'h0: t = 13'd1000;
         3'h1: t = 13'd125;
         3'h2: t = 13'd250;
         3'h3: t = 13'd500;
         3'h4: t = 13'd1250;
         3'h5: t = 13'd2500;
         3'h6: t = 13'd5000;
         3'h7: t = 13'd5000;
      endcase
      return t;
   endfunction : bwt_us

endpackage : cfg_pkg

// ===== core/link_watchdog.sv
// Communication watchdog counting microsecond ticks between valid frames.
// Assumes a one-cycle microsecond enable and a one-cycle frame pulse.
`timescale 1ns/1ps
module link_watchdog
   import cfg_pkg::*;
(
   // Clock and reset
   input  wire logic                i_sys_clk,
   input  wire logic                i_rst_b,
   // Timing and events
   input  wire logic                i_us_tick,
   input  wire logic                i_frame_ok,
   input  wire logic [3:0]          i_code,
   // Status
   output logic                     o_trip,
   output logic [WD_CNT_W-1:0]      o_count
);

   wd_state_e           state_reg,  state_next;
   logic [WD_CNT_W-1:0] cnt_reg,    cnt_next;
   logic [WD_CNT_W-1:0] limit;
   logic                direct;

   assign limit = wdt_us(i_code);
   assign direct = (i_code >= WDT_ZERO_MIN);

   always_comb
   begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      if (i_code == WDT_OFF)
      begin
         state_next = WD_OFF;
         cnt_next   = '0;
      end
      else if (direct)
      begin
         state_next = WD_TRIP;
         cnt_next   = '0;
      end
      else
      begin
         unique case (state_reg)
            WD_OFF:
            begin
               state_next = WD_RUN;
               cnt_next   = '0;
            end
            WD_RUN:
               if (i_frame_ok)
                  cnt_next = '0;
               else if (i_us_tick)
               begin
                  if (cnt_reg + 19'd1 >= limit)
                     state_next = WD_TRIP;
                  cnt_next = cnt_reg + 19'd1;
               end
            WD_TRIP:
               if (i_frame_ok)
               begin
                  state_next = WD_RUN;
                  cnt_next   = '0;
               end
            default:
               state_next = WD_OFF;
         endcase
      end
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         state_reg <= WD_OFF;
         cnt_reg   <= '0;
      end
      else
      begin
         state_reg <= state_next;
         cnt_reg   <= cnt_next;
      end
   end

   assign o_trip  = (state_reg == WD_TRIP);
   assign o_count = cnt_reg;

   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_b);

   property p_wd_direct;
      direct |=> o_trip;
   endproperty
   a_wd_direct: assert property (p_wd_direct)
      else $error("direct code did not trip watchdog");

   property p_wd_off;
      (i_code == WDT_OFF) |=> !o_trip && (o_count == '0);
   endproperty
   a_wd_off: assert property (p_wd_off)
      else $error("disabled watchdog tripped or counted");

   property p_wd_restart;
      (i_frame_ok && !direct && i_code != WDT_OFF) |=> o_count == '0;
   endproperty
   a_wd_restart: assert property (p_wd_restart)
      else $error("frame did not restart watchdog count");

   property p_wd_expire;
      (state_reg == WD_RUN && !i_frame_ok && i_us_tick && !direct
       && i_code != WDT_OFF && cnt_reg + 19'd1 >= limit) |=> o_trip;
   endproperty
   a_wd_expire: assert property (p_wd_expire)
      else $error("watchdog did not trip at timeout");

   property p_wd_early;
      (state_reg == WD_RUN && !direct && i_code != WDT_OFF
       && cnt_reg + 19'd1 < limit) |=> !o_trip;
   endproperty
   a_wd_early: assert property (p_wd_early)
      else $error("watchdog tripped before timeout");

endmodule : link_watchdog

// ===== testbench/host_model.sv
// Host model on the register port: byte writes, byte reads, frame events.
// Assumes the bench calls its tasks; all drive changes at the falling edge.
`timescale 1ns/1ps
module host_model
(
   // Clock
   input  wire logic       i_clk,
   // Register port answers
   input  wire logic [7:0] i_rdata,
   input  wire logic       i_rvalid,
   // Register port requests
   output logic            o_wr,
   output logic            o_rd,
   output logic [7:0]      o_addr,
   output logic [7:0]      o_wdata,
   output logic            o_frame
);
   initial
   begin
      o_wr    = 1'b0;
      o_rd    = 1'b0;
      o_addr  = 8'h00;
      o_wdata = 8'h00;
      o_frame = 1'b0;
   end

   // Released lines show the inverse so stale values never look valid.
   task automatic put_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_clk);
      o_wr    = 1'b1;
      o_addr  = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr    = 1'b0;
      o_addr  = ~a;
      o_wdata = ~d;
   endtask : put_wr

   task automatic get_rd(input logic [7:0] a, output logic [7:0] d,
                         output logic ok);
      @(negedge i_clk);
      o_rd   = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd   = 1'b0;
      o_addr = ~a;
      ok     = 1'b0;
      d      = 8'h00;
      for (int k = 0; k < 4 && !ok; k++)
      begin
         if (i_rvalid === 1'b1)
         begin
            d  = i_rdata;
            ok = 1'b1;
         end
         else
            @(negedge i_clk);
      end
   endtask : get_rd

   task automatic frame;
      @(negedge i_clk);
      o_frame = 1'b1;
      @(negedge i_clk);
      o_frame = 1'b0;
   endtask : frame
endmodule : host_model

// ===== testbench/link_cfg_regs_tb.sv
// Self-checking bench for the link configuration register bank.
// Assumes US_CYCLES of 1, so one microsecond is one clock cycle.
`timescale 1ns/1ps
module link_cfg_regs_tb
   import cfg_pkg::*;
;
   logic             I_SYS_CLK = 1'b0;
   logic             I_RST_B   = 1'b0;
   logic             wr, rd, rvalid, nvm_load, loaded, frame_ok, fs_exit;
   logic             fs_first, fs_second, pin2, pin1, pin0;
   logic             failsafe, ack;
   logic [7:0]       addr, wdata, rdata;
   logic [3:0]       bus_addr;
   logic [BWT_W-1:0] bwt;
   cfg_image_s       image;
   out_grp_s         norm, out_drive;
   int               fails, num_checks, i, n;
   logic [BWT_W-1:0] bwt_exp [8] = '{13'd1000, 13'd125, 13'd250, 13'd500,
                                     13'd1250, 13'd2500, 13'd5000, 13'd5000};

   always #20 I_SYS_CLK = ~I_SYS_CLK;

   link_cfg_regs #(.US_CYCLES(1)) link_cfg_regs_i (
      .I_SYS_CLK(I_SYS_CLK), .I_RST_B(I_RST_B), .i_reg_wr(wr),
      .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
      .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_nvm_load(nvm_load),
      .i_nvm_image(image), .o_cfg_loaded(loaded), .i_frame_ok(frame_ok),
      .i_fs_exit(fs_exit), .i_failsafe_input_first(fs_first),
      .i_failsafe_input_second(fs_second),
      .i_address_strap_pin_two(pin2), .i_address_strap_pin_one(pin1),
      .i_address_strap_pin_zero(pin0), .i_norm_drive(norm),
      .o_out_drive(out_drive), .o_failsafe(failsafe),
      .o_acknowledge_enable(ack), .o_break_wait_time_us(bwt),
      .o_bus_address(bus_addr));

   host_model host_model_i (
      .i_clk(I_SYS_CLK), .i_rdata(rdata), .i_rvalid(rvalid), .o_wr(wr),
      .o_rd(rd), .o_addr(addr), .o_wdata(wdata), .o_frame(frame_ok));

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   task automatic tally_and_finish;
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host_model_i.get_rd(a, d, ok);
      if (!ok)
      begin
         fails++;
         tally_and_finish();
      end
      chk(16'(d), 16'(exp));
   endtask : rd_chk

   task automatic cyc(input int c);
      repeat (c) @(negedge I_SYS_CLK);
   endtask : cyc

   // A bounded wait for fail-safe; an exhausted bound ends the run.
   task automatic wait_fs(input int lim, output int cnt);
      cnt = 0;
      while (failsafe !== 1'b1)
      begin
         @(negedge I_SYS_CLK);
         cnt++;
         if (cnt > lim)
         begin
            fails++;
            tally_and_finish();
         end
      end
   endtask : wait_fs

   task automatic exit_fs;
      host_model_i.put_wr(LINK_CFG_OFS, 8'h00);
      // The watchdog still shows its trip for one edge after code zero
      // lands, and a trip beats an exit request in the same cycle.
      cyc(2);
      fs_exit = 1'b1;
      cyc(1);
      fs_exit = 1'b0;
      cyc(3);
   endtask : exit_fs

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {nvm_load, fs_exit, fs_first, fs_second, pin2, pin1, pin0} = 7'h00;
      image = '0;
      norm  = 6'h2a;
      cyc(6);
      I_RST_B = 1'b1;
      cyc(1);
      chk(16'(loaded), 16'h0000);
      rd_chk(MAP_GH_OFS, 8'h00);
      image = '{addr_cfg: 8'hfa, link_cfg: 8'h0d, map_gh: 8'hff};
      nvm_load = 1'b1;
      cyc(1);
      nvm_load = 1'b0;
      cyc(2);
      chk(16'(loaded), 16'h0001);
      rd_chk(MAP_GH_OFS, 8'h77);
      rd_chk(LINK_CFG_OFS, 8'h0d);
      rd_chk(ADDR_CFG_OFS, 8'h1a);
      chk(16'(bus_addr), 16'h000a);
      host_model_i.put_wr(8'h86, 8'h5a);
      rd_chk(8'h86, 8'h00);
      host_model_i.put_wr(ADDR_CFG_OFS, 8'hea);
      rd_chk(ADDR_CFG_OFS, 8'h0a);
      {pin2, pin1, pin0} = 3'b101;
      cyc(8);
      chk(16'(bus_addr), 16'h0005);
      host_model_i.put_wr(ADDR_CFG_OFS, 8'h13);
      cyc(2);
      chk(16'(bus_addr), 16'h0003);
      for (i = 0; i < 8; i++)
      begin
         host_model_i.put_wr(LINK_CFG_OFS, {4'h0, i[2:0], ~i[0]});
         cyc(2);
         chk(16'(bwt), 16'(bwt_exp[i]));
         chk(16'(ack), 16'(!i[0]));
      end
      host_model_i.put_wr(LINK_CFG_OFS, 8'h10);
      rd_chk(LINK_CFG_OFS, 8'h10);
      repeat (3)
      begin
         cyc(150);
         host_model_i.frame();
      end
      chk(16'(failsafe), 16'h0000);
      wait_fs(260, n);
      chk(16'(n >= 190 && n <= 215), 16'h0001);
      exit_fs();
      chk(16'(failsafe), 16'h0000);
      cyc(300);
      chk(16'(failsafe), 16'h0000);
      for (i = 12; i < 16; i++)
      begin
         host_model_i.put_wr(LINK_CFG_OFS, {i[3:0], 4'h0});
         wait_fs(8, n);
         chk(16'(n <= 5), 16'h0001);
         fs_exit = 1'b1;
         cyc(1);
         fs_exit = 1'b0;
         chk(16'(failsafe), 16'h0001);
         if (i != 15)
            exit_fs();
      end
      host_model_i.put_wr(MAP_GH_OFS, 8'h50);
      fs_first = 1'b1;
      cyc(8);
      chk(16'(out_drive), 16'h0017);
      fs_first  = 1'b0;
      fs_second = 1'b1;
      cyc(8);
      chk(16'(out_drive), 16'h0028);
      exit_fs();
      chk(16'(out_drive), 16'h002a);
      tally_and_finish();
   end
endmodule : link_cfg_regs_tb
